/* inc/sprc_pkg.sv */
// Purpose: Shared constants for the scratchpad memory controller.
// Assumes: A 20 MHz core clock.
// Notes: Times are kept in picoseconds so that fractional nanosecond figures stay exact.
`default_nettype none
package sprc_pkg;
  // ====================================================================
  // Geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned WORDS = 64;
  // ====================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS = 50000;
  localparam int unsigned SEL_SETUP_PS = 2000;
  localparam int unsigned DATA_SETUP_PS = 7000;
  localparam int unsigned OUT_SETTLE_PS = 7000;
  localparam logic [3:0] SEL_SETUP_CYC = 4'((SEL_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] DATA_SETUP_CYC = 4'((DATA_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] OUT_SETTLE_CYC = 4'((OUT_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] ONE_CYC = 4'h1;
  localparam logic [3:0] ZERO_CYC = 4'h0;
  typedef enum logic [2:0] {
    SPRC_IDLE, SPRC_SETUP, SPRC_WPULSE, SPRC_RWAIT, SPRC_DONE
  } sprc_state_type;
endpackage : sprc_pkg
`default_nettype wire

/* inc/sprc_tmr_if.sv */
// Purpose: Link between the sequencer and its delay counter.
// Assumes: One clock domain.
// Notes: Load starts a count; expired is high once the count has run out.
`default_nettype none
interface sprc_tmr_if;
  logic load;
  logic [3:0] count;
  logic expired;
  modport owner (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface : sprc_tmr_if
`default_nettype wire

/* hw/sprc_timer.sv */
// Purpose: Down counter that measures waits in whole clock cycles.
// Assumes: Load is a one-cycle pulse.
// Notes: A load of N makes expired rise N cycles after the load edge.
`default_nettype none
module sprc_timer
  import sprc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  sprc_tmr_if.timer tmr
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (tmr.load) begin
      cnt_d = tmr.count;
    end else if (cnt_q != ZERO_CYC) begin
      cnt_d = cnt_q - ONE_CYC;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Expired looks only at the count. The sequencer decides load from expired,
  // so a path back through load would close a combinational loop.
  assign tmr.expired = (cnt_q == ZERO_CYC);
endmodule : sprc_timer
`default_nettype wire

/* hw/sprc_ctrl.sv */
// Summary of operation
// RULE1: The memory holds 64 one-bit words, one chosen by full address decode.
// RULE2: The controller drives the binary location index on six address pins.
// RULE3: Read with both selects low and read/write high; the memory drives data.
// RULE4: Reads do not disturb stored bits; repeated reads give the same value.
// RULE5: Write stores data in when both selects low and read/write pulses low.
// RULE6: Start the write pulse only after address valid and selects low 2.0 ns.
// RULE7: Hold data in stable during the final 7.0 ns of the write pulse.
// RULE8: Either select high forces the memory output low.
// RULE9: After a select rises, output falls between 3.0 and 7.0 ns.
// RULE10: After both selects fall, output stays low 3.0 to 7.0 ns before data.
// RULE11: Output is wired-OR capable; deselected parts contribute low.
// RULE12: Two independent active-low selects, e.g. row and column decode.
// RULE13: No location changes while read/write is high or a select is high.
// RULE14: Keep the address stable throughout the write pulse.
//
// Purpose: Controller that drives a 64x1 scratchpad memory through its pins.
// Assumes: Requests are synchronous to core_clk_i; memory data arrives synchronously.
// Notes: One access at a time; a new request is taken only in idle.
`default_nettype none
module sprc_ctrl
  import sprc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_wdata_i,
  input wire logic req_row_sel_i,
  input wire logic req_col_sel_i,
  input wire logic mem_dout_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_rdata_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_sel_a_n_o,
  output logic mem_sel_b_n_o,
  output logic mem_rw_n_o,
  output logic mem_din_o
);
  // ====================================================================
  // State
  sprc_state_type state_q;
  sprc_state_type state_d;
  logic write_q;
  logic write_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic din_q;
  logic din_d;
  logic sel_a_n_q;
  logic sel_a_n_d;
  logic sel_b_n_q;
  logic sel_b_n_d;
  logic rw_n_q;
  logic rw_n_d;
  logic ready_q;
  logic ready_d;
  logic rsp_q;
  logic rsp_d;
  logic rdata_q;
  logic rdata_d;

  // One timer serves select setup, pulse width and output settle.
  // These waits never overlap, so a second counter would buy nothing.
  sprc_tmr_if tmr ();

  sprc_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tmr(tmr)
  );

  // ====================================================================
  // Sequencer
  // Selects lead the write pulse, and address and data are frozen from the
  // request edge until the selects are released, so the pulse never sees a
  // moving address or data bit.
  always_comb begin
    state_d = state_q;
    write_d = write_q;
    addr_d = addr_q;
    din_d = din_q;
    sel_a_n_d = sel_a_n_q;
    sel_b_n_d = sel_b_n_q;
    rw_n_d = rw_n_q;
    ready_d = ready_q;
    rsp_d = 1'b0;
    rdata_d = rdata_q;
    tmr.load = 1'b0;
    tmr.count = ZERO_CYC;
    case (state_q)
      SPRC_IDLE: begin
        if (req_valid_i && ready_q) begin
          write_d = req_write_i;
          addr_d = req_addr_i; // RULE2
          din_d = req_wdata_i;
          sel_a_n_d = !req_row_sel_i; // RULE12
          sel_b_n_d = !req_col_sel_i; // RULE12
          rw_n_d = 1'b1; // RULE13
          ready_d = 1'b0;
          tmr.load = 1'b1;
          if (req_write_i) begin
            tmr.count = SEL_SETUP_CYC; // RULE6
            state_d = SPRC_SETUP;
          end else begin
            tmr.count = OUT_SETTLE_CYC; // RULE10
            state_d = SPRC_RWAIT;
          end
        end
      end
      SPRC_SETUP: begin
        // The pulse lasts one load cycle plus the count, which is longer than needed.
        // That is the price of rounding every wait up to whole clock cycles.
        if (tmr.expired) begin
          rw_n_d = 1'b0; // RULE5
          tmr.load = 1'b1;
          tmr.count = DATA_SETUP_CYC; // RULE7
          state_d = SPRC_WPULSE;
        end
      end
      SPRC_WPULSE: begin
        if (tmr.expired) begin
          rw_n_d = 1'b1; // RULE14
          state_d = SPRC_DONE;
        end
      end
      SPRC_RWAIT: begin
        if (tmr.expired) begin
          // A deselected part reads as low on the wired-OR line.
          rdata_d = mem_dout_i; // RULE3 RULE11
          rsp_d = 1'b1;
          state_d = SPRC_DONE;
        end
      end
      SPRC_DONE: begin
        // Selects go high only after read/write is back high, so no location can change.
        sel_a_n_d = 1'b1; // RULE13
        sel_b_n_d = 1'b1; // RULE8
        rsp_d = write_q;
        tmr.load = 1'b1;
        tmr.count = OUT_SETTLE_CYC; // RULE9
        state_d = SPRC_IDLE;
      end
      default: begin
        state_d = SPRC_IDLE;
      end
    endcase
    // Ready returns once the output of the released part has had time to fall.
    if (state_q == SPRC_IDLE && !ready_q && tmr.expired) begin
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SPRC_IDLE;
      write_q <= 1'b0;
      addr_q <= '0;
      din_q <= 1'b0;
      sel_a_n_q <= 1'b1;
      sel_b_n_q <= 1'b1;
      rw_n_q <= 1'b1;
      ready_q <= 1'b0;
      rsp_q <= 1'b0;
      rdata_q <= 1'b0;
    end else begin
      state_q <= state_d;
      write_q <= write_d;
      addr_q <= addr_d;
      din_q <= din_d;
      sel_a_n_q <= sel_a_n_d;
      sel_b_n_q <= sel_b_n_d;
      rw_n_q <= rw_n_d;
      ready_q <= ready_d;
      rsp_q <= rsp_d;
      rdata_q <= rdata_d;
    end
  end

  // ====================================================================
  // Outputs
  assign req_ready_o = ready_q;
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = rdata_q;
  assign mem_addr_o = addr_q;
  assign mem_sel_a_n_o = sel_a_n_q;
  assign mem_sel_b_n_o = sel_b_n_q;
  assign mem_rw_n_o = rw_n_q;
  assign mem_din_o = din_q;
endmodule : sprc_ctrl
`default_nettype wire

/* tb/sprc_mem_model.sv */
// Purpose: Behavioural 64x1 scratchpad memory.
// Assumes: A write lands on the rising read/write edge.
// Notes: The output is driven to 0 while either select is high, so a deselected part reads 0.
`default_nettype none
module sprc_mem_model
  import sprc_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic sel_a_n_i,
  input wire logic sel_b_n_i,
  input wire logic rw_n_i,
  input wire logic din_i,
  output logic dout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mem_q [WORDS];
  wire logic sel = !sel_a_n_i && !sel_b_n_i;
  always @(posedge rw_n_i) if (sel) mem_q[addr_i] = din_i;
  assign #5 dout_o = sel ? mem_q[addr_i] : 1'b0;
endmodule : sprc_mem_model
`default_nettype wire

/* tb/sprc_ctrl_asserts.sv */
// Purpose: Pin sequence checks for sprc_ctrl.
// Assumes: One clock, asynchronous reset.
// Notes: Bound into every sprc_ctrl.
`default_nettype none
module sprc_ctrl_asserts
  import sprc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic req_row_sel_i,
  input wire logic req_col_sel_i,
  input wire logic mem_dout_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic rsp_rdata_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_sel_a_n_o,
  input wire logic mem_sel_b_n_o,
  input wire logic mem_rw_n_o,
  input wire logic mem_din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = req_valid_i && req_ready_o;
  sequence pins_wait;
    (mem_rw_n_o && !rsp_valid_o)[*2];
  endsequence
  sequence wr_pulse;
    (!mem_rw_n_o)[*2] ##1 mem_rw_n_o;
  endsequence
  sel_setup_a: assert property ($fell(mem_rw_n_o) |-> $stable(mem_sel_a_n_o) && $stable(mem_sel_b_n_o))
    else $error("select moved at pulse start");
  din_hold_a: assert property (!mem_rw_n_o |-> $stable(mem_din_o) ##1 $stable(mem_din_o))
    else $error("data in moved in pulse");
  addr_hold_a: assert property (!mem_rw_n_o |-> $stable(mem_addr_o) ##1 $stable(mem_addr_o))
    else $error("address moved in pulse");
  wr_seq_a: assert property (take && req_write_i |-> ##1 pins_wait ##1 wr_pulse ##1 rsp_valid_o)
    else $error("write sequence wrong");
  rd_seq_a: assert property (take && !req_write_i |-> ##1 pins_wait ##1 rsp_valid_o)
    else $error("read sequence wrong");
  rd_data_a: assert property (rsp_valid_o && $past(mem_rw_n_o, 2) |-> rsp_rdata_o == $past(mem_dout_i))
    else $error("read bit not from memory");
  sel_map_a: assert property (take |=> mem_sel_a_n_o == !$past(req_row_sel_i)
    && mem_sel_b_n_o == !$past(req_col_sel_i) && mem_addr_o == $past(req_addr_i))
    else $error("pins do not follow request");
  idle_safe_a: assert property (req_ready_o |-> mem_sel_a_n_o && mem_sel_b_n_o && mem_rw_n_o)
    else $error("pins active while idle");
endmodule : sprc_ctrl_asserts
bind sprc_ctrl sprc_ctrl_asserts u_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .req_valid_i(req_valid_i),
  .req_write_i(req_write_i),
  .req_addr_i(req_addr_i),
  .req_row_sel_i(req_row_sel_i),
  .req_col_sel_i(req_col_sel_i),
  .mem_dout_i(mem_dout_i),
  .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o),
  .rsp_rdata_o(rsp_rdata_o),
  .mem_addr_o(mem_addr_o),
  .mem_sel_a_n_o(mem_sel_a_n_o),
  .mem_sel_b_n_o(mem_sel_b_n_o),
  .mem_rw_n_o(mem_rw_n_o),
  .mem_din_o(mem_din_o)
);
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Drive sprc_ctrl against a memory model and predict reads.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes: An unselected read expects 0, which the memory model drives when deselected.
`default_nettype none
module tb_top
  import sprc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic req_wdata_i = 1'b0;
  logic req_row_sel_i = 1'b0;
  logic req_col_sel_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [ADDR_W-1:0] mem_addr_o;
  logic mem_dout_i, req_ready_o, rsp_valid_o, rsp_rdata_o, mem_sel_a_n_o, mem_sel_b_n_o, mem_rw_n_o, mem_din_o;
  logic exp_q [WORDS];
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  sprc_ctrl dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .req_valid_i(req_valid_i),
    .req_write_i(req_write_i),
    .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i),
    .req_row_sel_i(req_row_sel_i),
    .req_col_sel_i(req_col_sel_i),
    .mem_dout_i(mem_dout_i),
    .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o),
    .mem_addr_o(mem_addr_o),
    .mem_sel_a_n_o(mem_sel_a_n_o),
    .mem_sel_b_n_o(mem_sel_b_n_o),
    .mem_rw_n_o(mem_rw_n_o),
    .mem_din_o(mem_din_o)
  );
  sprc_mem_model u_mem (.addr_i(mem_addr_o), .sel_a_n_i(mem_sel_a_n_o), .sel_b_n_i(mem_sel_b_n_o),
    .rw_n_i(mem_rw_n_o), .din_i(mem_din_o), .dout_o(mem_dout_i));
  initial forever #25 core_clk_i = ~core_clk_i;
  task automatic chk(input logic got, input logic want);
    samples_checked++;
    if (got !== want) begin
      miscompares++;
      $display("BAD %0t got %b want %b", $time, got, want);
    end
  endtask : chk
  task automatic end_sim();
    $display("checked %0d bad %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  function automatic logic rd_want(input logic [ADDR_W-1:0] a, input logic r, input logic c);
    return (r && c) ? exp_q[a] : 1'b0;
  endfunction : rd_want
  task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic d, input logic r, input logic c);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #2;
      n++;
    end
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_row_sel_i, req_col_sel_i} = {1'b1, w, a, d, r, c};
    do begin
      @(posedge core_clk_i);
      #2;
      req_valid_i = 1'b0;
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 40);
    chk(rsp_valid_o, 1'b1);
    if (!w) chk(rsp_rdata_o, rd_want(a, r, c));
    else if (r && c) exp_q[a] = d;
  endtask : op
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 12000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h2DE6));
    repeat (16) @(posedge core_clk_i);
    #2;
    rst_i = 1'b0;
    for (int i = 0; i < WORDS; i++) op(1'b1, ADDR_W'(i), 1'($urandom), 1'b1, 1'b1);
    $display("test fill done");
    repeat (2) for (int i = 0; i < WORDS; i++) op(1'b0, ADDR_W'(i), 1'b0, 1'b1, 1'b1);
    $display("test reread done");
    for (int i = 0; i < 2; i++) begin
      op(1'b1, ADDR_W'(i * 63), ~exp_q[i * 63], 1'b1, 1'b1);
      op(1'b0, ADDR_W'(i * 63), 1'b0, 1'b1, 1'b1);
    end
    $display("test edge done");
    repeat (300) op(1'($urandom), ADDR_W'($urandom), 1'($urandom), $urandom % 4 > 0, $urandom % 4 > 0);
    $display("test random done");
    rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #2;
    chk(req_ready_o | rsp_valid_o | rsp_rdata_o, 1'b0);
    chk(mem_sel_a_n_o & mem_sel_b_n_o & mem_rw_n_o, 1'b1);
    rst_i = 1'b0;
    repeat (4) op(1'b0, ADDR_W'($urandom), 1'b0, 1'b1, 1'b1);
    $display("test reset done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
